// ---- shared/ddrtr_pkg.sv ----
// Purpose: shared constants and carriers for the dram-side timing checker
// Assumes: one 25 MHz clock; the memory's command pins are sampled on it
// Notes:   times are in ps; TNRP_NCK is derived from the clock period, other counts are given in clocks
package ddrtr_pkg;
   localparam int unsigned TCK_PS         = 40000;
   localparam int unsigned TRP_PS         = 15000;
   localparam int unsigned TWTR_NCK       = 2;
   localparam int unsigned TCKE_NCK       = 3;
   localparam int unsigned TAOND_NCK      = 2;
   localparam int unsigned TAOFD_EDGES    = 2;
   localparam int unsigned MR_STROBE_BIT  = 10;
   localparam int unsigned MR_WR_LSB      = 9;
   localparam int unsigned MR_WR_W        = 3;
   localparam int unsigned ROWS_W         = 4;
   localparam int unsigned ROWS           = 16;
   localparam int unsigned CNT_W          = 5;

   // round-up conversion of a time into whole clocks
   function automatic logic [CNT_W-1:0] ru_clk(input int unsigned t_ps);
      int unsigned q;
      q = (t_ps + TCK_PS - 1) / TCK_PS;
      if (q == 0) begin
         q = 1;
      end
      ru_clk = CNT_W'(q);
   endfunction

   localparam logic [CNT_W-1:0] TNRP_NCK = ru_clk(TRP_PS);

   typedef enum logic [2:0] {
      DDRTR_CMD_NOP,
      DDRTR_CMD_ACT,
      DDRTR_CMD_WRAP,
      DDRTR_CMD_WR,
      DDRTR_CMD_RD,
      DDRTR_CMD_MRS
   } ddrtr_cmd_e;

   typedef struct packed {
      ddrtr_cmd_e            cmd;
      logic [ROWS_W-1:0]     row;
      logic [12:0]           addr;
      logic                  data_ok;
   } ddrtr_req_s;

   typedef struct packed {
      logic dal_err;
      logic wtr_err;
      logic cke_err;
      logic rd_stale;
   } ddrtr_err_s;
endpackage

// ---- design/ddrtr_valid_mem.sv ----
// Purpose: one valid bit per tracked row, registered read
// Assumes: single clock, write and read may coincide
// Notes:   read data shows the stored value before a same-cycle write
`timescale 1ns/1ps
module ddrtr_valid_mem
   import ddrtr_pkg::*;
(
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // write port
   input  wire logic              we_i,
   input  wire logic [ROWS_W-1:0] waddr_i,
   input  wire logic              wdata_i,
   // read port
   input  wire logic [ROWS_W-1:0] raddr_i,
   output      logic              rdata_o
);
   logic [ROWS-1:0] bits_reg;
   logic [ROWS-1:0] bits_next;
   logic            rdata_next;

   always_comb begin
      bits_next = bits_reg;
      if (we_i) begin
         bits_next[waddr_i] = wdata_i;
      end
      rdata_next = bits_reg[raddr_i];
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         bits_reg <= '1;
         rdata_o  <= 1'b1;
      end else begin
         bits_reg <= bits_next;
         rdata_o  <= rdata_next;
      end
   end
endmodule

// ---- design/ddrtr_core.sv ----
// Purpose: dram-side command timing: recovery, turnaround, cke pulse, odt reference, strobe mode
// Assumes: commands arrive already decoded on the device clock; clock changes only when idle
// Notes:   violations are flagged, not blocked; the dram keeps running
// Notes on behaviour
// - The clock may change only in self-refresh or precharge power-down, with a procedure for the latter; code allows it whenever CKE is validly low.
// - Termination turn-on reference is two clocks after the edge that first sees termination control high.
// - Termination turn-off reference is half a clock after the second trailing edge after control goes low.
// - Mode bit 10 at zero selects the differential strobe pair, at one a single-ended strobe.
// - Nanosecond parameters are honoured as rounded-up clock counts.
// - Clock counts are counted in real clock edges, not elapsed time.
`timescale 1ns/1ps
module ddrtr_core
   import ddrtr_pkg::*;
(
   // clock and reset
   input  wire logic       SYS_CLK_I,
   input  wire logic       SYS_RST_I,
   // decoded command from the controller
   input  wire ddrtr_req_s REQ_I,
   input  wire logic       WDATA_END_I,
   // pin levels from outside the clock domain
   input  wire logic       CKE_PIN_I,
   input  wire logic       ODT_PIN_I,
   // status toward the array
   output      logic       CKE_VALID_O,
   output      logic       ODT_ON_REF_O,
   output      logic       ODT_OFF_REF_O,
   output      logic       STROBE_DIFF_O,
   output      logic       CLK_CHANGE_OK_O,
   output      logic       RD_VALID_O,
   output      ddrtr_err_s ERR_O
);
   // three-stage input capture; stage one only feeds stage two
   logic [2:0] cke_sync_reg, odt_sync_reg;
   logic [2:0] cke_sync_next, odt_sync_next;
   logic       cke_lvl_reg, cke_lvl_next, odt_lvl_reg, odt_lvl_next;

   always_comb begin
      cke_sync_next = {cke_sync_reg[1:0], CKE_PIN_I};
      odt_sync_next = {odt_sync_reg[1:0], ODT_PIN_I};
      cke_lvl_next  = (cke_sync_reg[1] == cke_sync_reg[2]) ? cke_sync_reg[2] : cke_lvl_reg;
      odt_lvl_next  = (odt_sync_reg[1] == odt_sync_reg[2]) ? odt_sync_reg[2] : odt_lvl_reg;
   end

   always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         cke_sync_reg <= 3'h0;
         odt_sync_reg <= 3'h0;
         cke_lvl_reg  <= 1'b0;
         odt_lvl_reg  <= 1'b0;
      end else begin
         cke_sync_reg <= cke_sync_next;
         odt_sync_reg <= odt_sync_next;
         cke_lvl_reg  <= cke_lvl_next;
         odt_lvl_reg  <= odt_lvl_next;
      end
   end

   // mode register and timing counters
   logic [MR_WR_W-1:0] wr_mr_reg, wr_mr_next;
   logic               strobe_se_reg, strobe_se_next;
   logic [CNT_W-1:0]   dal_cnt_reg, dal_cnt_next;
   logic [CNT_W-1:0]   wtr_cnt_reg, wtr_cnt_next;
   logic [CNT_W-1:0]   cke_cnt_reg, cke_cnt_next;
   logic               cke_prev_reg, cke_prev_next;
   logic               cke_valid_next;
   ddrtr_err_s         err_next;

   always_comb begin
      wr_mr_next     = wr_mr_reg;
      strobe_se_next = strobe_se_reg;
      dal_cnt_next   = (dal_cnt_reg != '0) ? dal_cnt_reg - CNT_W'(1) : dal_cnt_reg;
      wtr_cnt_next   = (wtr_cnt_reg != '0) ? wtr_cnt_reg - CNT_W'(1) : wtr_cnt_reg;
      cke_prev_next  = cke_lvl_reg;
      cke_cnt_next   = cke_cnt_reg;
      err_next       = '0;
      if (REQ_I.cmd == DDRTR_CMD_MRS) begin
         wr_mr_next     = REQ_I.addr[MR_WR_LSB +: MR_WR_W];
         strobe_se_next = REQ_I.addr[MR_STROBE_BIT];
      end
      if (REQ_I.cmd == DDRTR_CMD_WRAP) begin
         // mode field codes recovery minus one; loading the total less one lets the
         // count reach zero on the edge where the activate first becomes legal
         dal_cnt_next = CNT_W'(wr_mr_reg) + TNRP_NCK;
      end
      if (REQ_I.cmd == DDRTR_CMD_ACT && dal_cnt_reg != '0) begin
         err_next.dal_err = 1'b1;
      end
      if (WDATA_END_I) begin
         wtr_cnt_next = CNT_W'(TWTR_NCK);
      end
      if (REQ_I.cmd == DDRTR_CMD_RD && wtr_cnt_reg != '0) begin
         err_next.wtr_err = 1'b1;
      end
      if (cke_lvl_reg != cke_prev_reg) begin
         cke_cnt_next = CNT_W'(1);
         if (cke_cnt_reg < CNT_W'(TCKE_NCK)) begin
            err_next.cke_err = 1'b1;
         end
      end else if (cke_cnt_reg < CNT_W'(TCKE_NCK)) begin
         cke_cnt_next = cke_cnt_reg + CNT_W'(1);
      end
      cke_valid_next = (cke_cnt_next >= CNT_W'(TCKE_NCK));
   end

   always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         wr_mr_reg     <= '0;
         strobe_se_reg <= 1'b0;
         dal_cnt_reg   <= '0;
         wtr_cnt_reg   <= '0;
         cke_cnt_reg   <= '0;
         cke_prev_reg  <= 1'b0;
         CKE_VALID_O   <= 1'b0;
         ERR_O         <= '0;
      end else begin
         wr_mr_reg     <= wr_mr_next;
         strobe_se_reg <= strobe_se_next;
         dal_cnt_reg   <= dal_cnt_next;
         wtr_cnt_reg   <= wtr_cnt_next;
         cke_cnt_reg   <= cke_cnt_next;
         cke_prev_reg  <= cke_prev_next;
         CKE_VALID_O   <= cke_valid_next;
         ERR_O         <= err_next;
      end
   end

   assign STROBE_DIFF_O = ~strobe_se_reg;
   // frequency change safe only while clock enable is validly low; the previous level is
   // checked too, since the valid flag still shows the old level for one cycle after a fall
   assign CLK_CHANGE_OK_O = CKE_VALID_O & ~cke_lvl_reg & ~cke_prev_reg;

   // termination reference points; the half-clock offset rides on the falling edge of the
   // selected cycle, so the turn-off pulse marks the cycle that ends with that trailing edge
   typedef enum logic [1:0] {ODT_IDLE, ODT_ONWAIT, ODT_ACTIVE, ODT_OFFWAIT} ddrtr_odt_e;
   ddrtr_odt_e       odt_st_reg, odt_st_next;
   logic [CNT_W-1:0] odt_cnt_reg, odt_cnt_next;
   logic             on_ref_next, off_ref_next;

   always_comb begin
      odt_st_next  = odt_st_reg;
      odt_cnt_next = odt_cnt_reg;
      on_ref_next  = 1'b0;
      off_ref_next = 1'b0;
      case (odt_st_reg)
         ODT_IDLE: begin
            if (odt_lvl_reg) begin
               odt_st_next  = ODT_ONWAIT;
               odt_cnt_next = CNT_W'(TAOND_NCK - 1);
            end
         end
         ODT_ONWAIT: begin
            if (odt_cnt_reg == '0) begin
               on_ref_next = 1'b1;
               odt_st_next = ODT_ACTIVE;
            end else begin
               odt_cnt_next = odt_cnt_reg - CNT_W'(1);
            end
         end
         ODT_ACTIVE: begin
            if (!odt_lvl_reg) begin
               odt_st_next  = ODT_OFFWAIT;
               odt_cnt_next = CNT_W'(TAOFD_EDGES - 1);
            end
         end
         default: begin
            if (odt_cnt_reg == '0) begin
               off_ref_next = 1'b1;
               odt_st_next  = ODT_IDLE;
            end else begin
               odt_cnt_next = odt_cnt_reg - CNT_W'(1);
            end
         end
      endcase
   end

   always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         odt_st_reg    <= ODT_IDLE;
         odt_cnt_reg   <= '0;
         ODT_ON_REF_O  <= 1'b0;
         ODT_OFF_REF_O <= 1'b0;
      end else begin
         odt_st_reg    <= odt_st_next;
         odt_cnt_reg   <= odt_cnt_next;
         ODT_ON_REF_O  <= on_ref_next;
         ODT_OFF_REF_O <= off_ref_next;
      end
   end

   // per-row data validity; a bad write poisons the row until a clean rewrite
   logic row_we;
   logic mem_rd;
   logic rd_pend_reg, rd_pend_next;

   assign row_we = (REQ_I.cmd == DDRTR_CMD_WR) || (REQ_I.cmd == DDRTR_CMD_WRAP);

   ddrtr_valid_mem u_valid (
      .clk_i   (SYS_CLK_I),
      .rst_i   (SYS_RST_I),
      .we_i    (row_we),
      .waddr_i (REQ_I.row),
      .wdata_i (REQ_I.data_ok),
      .raddr_i (REQ_I.row),
      .rdata_o (mem_rd)
   );

   always_comb begin
      rd_pend_next = (REQ_I.cmd == DDRTR_CMD_RD);
   end

   always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         rd_pend_reg <= 1'b0;
      end else begin
         rd_pend_reg <= rd_pend_next;
      end
   end

   assign RD_VALID_O = rd_pend_reg & mem_rd;

   a_wtr_flag: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      WDATA_END_I ##1 (REQ_I.cmd == DDRTR_CMD_RD) |=> ERR_O.wtr_err)
      else $error("read too soon after write data not flagged");
   a_odt_on_time: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      (odt_st_reg == ODT_IDLE && odt_lvl_reg) |=> !ODT_ON_REF_O ##1 !ODT_ON_REF_O ##1 ODT_ON_REF_O)
      else $error("termination turn-on reference not two clocks late");
   a_odt_off_time: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      (odt_st_reg == ODT_ACTIVE && !odt_lvl_reg) |=> !ODT_OFF_REF_O ##1 !ODT_OFF_REF_O ##1 ODT_OFF_REF_O)
      else $error("termination turn-off reference misplaced");
   a_cke_three: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      $rose(CKE_VALID_O) |-> ($past(cke_lvl_reg) == cke_lvl_reg && $past(cke_lvl_reg, 2) == cke_lvl_reg))
      else $error("clock enable valid before three samples");
   a_cke_hold: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      ($changed(cke_lvl_reg) && cke_cnt_reg < CNT_W'(TCKE_NCK)) |=> ERR_O.cke_err)
      else $error("short clock-enable pulse not flagged");
   a_dal_load: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      (REQ_I.cmd == DDRTR_CMD_WRAP) |=> dal_cnt_reg == CNT_W'($past(wr_mr_reg)) + TNRP_NCK)
      else $error("recovery count wrong after auto-precharge write");
   a_dal_act: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      (REQ_I.cmd == DDRTR_CMD_WRAP && wr_mr_reg >= MR_WR_W'(2)) ##1 (REQ_I.cmd == DDRTR_CMD_NOP) [*2]
      ##1 (REQ_I.cmd == DDRTR_CMD_ACT) |=> ERR_O.dal_err)
      else $error("early activate not flagged");
   a_mr_wr: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      (REQ_I.cmd == DDRTR_CMD_MRS) |=> wr_mr_reg == $past(REQ_I.addr[MR_WR_LSB +: MR_WR_W]))
      else $error("recovery field not taken from mode write");
   a_strobe_mode: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      (REQ_I.cmd == DDRTR_CMD_MRS) |=> STROBE_DIFF_O == !$past(REQ_I.addr[MR_STROBE_BIT]))
      else $error("strobe mode not following mode bit");
   a_bad_write: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      (row_we && !REQ_I.data_ok) ##1 (!row_we) [*2] ##1 (REQ_I.cmd == DDRTR_CMD_RD
      && REQ_I.row == $past(REQ_I.row, 3)) |=> !RD_VALID_O)
      else $error("read of corrupted row reported valid");
   a_clk_change: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      CLK_CHANGE_OK_O |-> (!cke_lvl_reg && !$past(cke_lvl_reg) && !$past(cke_lvl_reg, 2)))
      else $error("clock change allowed while clock enable high");
endmodule

// ---- dv/ddrtr_ctrl_model.sv ----
// Purpose: controller-side command source facing the timing core
// Assumes: one clock; every request changes just after a rising edge
// Notes:   spacing comes from the caller, so a violation happens only when a scenario asks for it
`timescale 1ns/1ps
module ddrtr_ctrl_model
   import ddrtr_pkg::*;
(
   // clock
   input  wire logic       clk_i,
   // command and pins toward the memory
   output      ddrtr_req_s req_o,
   output      logic       wdata_end_o,
   output      logic       cke_o,
   output      logic       odt_o
);
   initial begin
      req_o       = '0;
      wdata_end_o = 1'b0;
      cke_o       = 1'b0;
      odt_o       = 1'b0;
   end

   // one command per edge; nop fill keeps the bus defined between commands
   task automatic step(input ddrtr_cmd_e c, input logic [ROWS_W-1:0] r, input logic [12:0] a,
                       input logic ok, input logic wend);
      @(posedge clk_i);
      req_o       <= '{cmd: c, row: r, addr: a, data_ok: ok};
      wdata_end_o <= wend;
   endtask

   task automatic idle(input int n);
      repeat (n) step(DDRTR_CMD_NOP, 4'h0, 13'h0000, 1'b1, 1'b0);
   endtask

   // activate comes gap clocks after the write; legal once gap reaches mode value plus one plus TNRP_NCK
   task automatic wrap_act(input int gap, input logic [ROWS_W-1:0] r);
      step(DDRTR_CMD_WRAP, r, 13'(gap), 1'b1, 1'b1);
      idle(gap - 1);
      step(DDRTR_CMD_ACT, r, 13'(gap), 1'b0, 1'b0);
   endtask

   // a gap below three is only asked for when the turnaround flag is wanted
   task automatic wr_rd(input int gap, input logic [ROWS_W-1:0] r, input logic ok);
      step(DDRTR_CMD_WR, r, {9'h000, r}, ok, 1'b1);
      idle(gap - 1);
      // the read carries the opposite quality bit, which must not touch the row
      step(DDRTR_CMD_RD, r, {9'h000, r}, ~ok, 1'b0);
   endtask

   // holding three or more clocks meets the minimum pulse
   task automatic cke_hold(input logic v, input int n);
      @(posedge clk_i);
      cke_o <= v;
      repeat (n - 1) @(posedge clk_i);
   endtask

   task automatic set_odt(input logic v);
      @(posedge clk_i);
      odt_o <= v;
   endtask
endmodule

// ---- dv/ddrtr_core_tb.sv ----
// Purpose: self-checking bench for the dram-side timing core
// Assumes: pin changes reach the core four edges late through its capture and filter flops
// Notes:   pulses are caught by a monitor that accumulates them between clears
`timescale 1ns/1ps
module ddrtr_core_tb
   import ddrtr_pkg::*;
;
   logic       sys_clk;
   logic       sys_rst;
   ddrtr_req_s req;
   logic       wend;
   logic       cke;
   logic       odt;
   logic       cke_valid;
   logic       on_ref;
   logic       off_ref;
   logic       strobe_diff;
   logic       clk_ok;
   logic       rd_valid;
   ddrtr_err_s err;
   logic [3:0] seen_err;
   logic       seen_rdv;
   int         n_mismatch = 0;
   int         num_checks = 0;
   int         cycles = 0;

   ddrtr_core i_ddrtr_core (.SYS_CLK_I(sys_clk), .SYS_RST_I(sys_rst), .REQ_I(req), .WDATA_END_I(wend),
      .CKE_PIN_I(cke), .ODT_PIN_I(odt), .CKE_VALID_O(cke_valid), .ODT_ON_REF_O(on_ref),
      .ODT_OFF_REF_O(off_ref), .STROBE_DIFF_O(strobe_diff), .CLK_CHANGE_OK_O(clk_ok),
      .RD_VALID_O(rd_valid), .ERR_O(err));
   ddrtr_ctrl_model i_ddrtr_ctrl_model (.clk_i(sys_clk), .req_o(req), .wdata_end_o(wend),
      .cke_o(cke), .odt_o(odt));

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   // one-cycle pulses are easy to miss from a task, so gather them here
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      seen_err <= seen_err | err;
      if (rd_valid === 1'b1) begin
         seen_rdv <= 1'b1;
      end
      if (cycles == 3000) begin
         n_mismatch++;
         conclude();
      end
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected t=%0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic clr();
      #1;
      seen_err = 4'h0;
      seen_rdv = 1'b0;
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic t_reset();
      check({2'b00, cke_valid, on_ref, off_ref, strobe_diff, clk_ok, rd_valid}, 8'h04, "reset outputs");
      check({4'h0, err}, 8'h00, "reset errors");
   endtask

   // two mode values: each sets strobe form and the recovery used for activate spacing
   task automatic t_mode_dal();
      logic [2:0] w;
      int         tdal;
      for (int i = 0; i < 2; i++) begin
         w = (i == 0) ? 3'b101 : 3'b010;
         i_ddrtr_ctrl_model.step(DDRTR_CMD_MRS, 4'h0, {1'b0, w, 9'h000}, 1'b1, 1'b0);
         i_ddrtr_ctrl_model.idle(2);
         check({7'h00, strobe_diff}, {7'h00, ~w[1]}, "strobe form");
         tdal = int'(w) + 1 + int'(TNRP_NCK);
         for (int gap = tdal - 1; gap <= tdal; gap++) begin
            i_ddrtr_ctrl_model.idle(4);
            clr();
            i_ddrtr_ctrl_model.wrap_act(gap, 4'(gap));
            i_ddrtr_ctrl_model.idle(3);
            check({7'h00, seen_err[3]}, {7'h00, gap < tdal}, "activate recovery");
         end
      end
   endtask

   task automatic t_wtr();
      for (int g = 1; g <= 3; g++) begin
         i_ddrtr_ctrl_model.idle(4);
         clr();
         i_ddrtr_ctrl_model.wr_rd(g, 4'h2, 1'b1);
         i_ddrtr_ctrl_model.idle(4);
         check({7'h00, seen_err[2]}, {7'h00, g <= int'(TWTR_NCK)}, "write to read");
      end
   endtask

   // a corrupted write leaves the row unreadable until a clean rewrite
   task automatic t_stale();
      for (int i = 0; i < 2; i++) begin
         i_ddrtr_ctrl_model.idle(4);
         clr();
         i_ddrtr_ctrl_model.wr_rd(3, 4'h5, i[0]);
         i_ddrtr_ctrl_model.idle(4);
         check({7'h00, seen_rdv}, {7'h00, i[0]}, "read after write");
         check({4'h0, seen_err}, 8'h00, "no flags");
      end
   endtask

   task automatic edges_to(input logic sel, output int k);
      for (k = 1; k <= 12; k++) begin
         @(posedge sys_clk);
         #1;
         if ((sel ? off_ref : on_ref) === 1'b1) begin
            break;
         end
      end
   endtask

   // four capture edges, the registering edge, then two clocks to the reference
   task automatic t_odt();
      int k;
      i_ddrtr_ctrl_model.set_odt(1'b1);
      edges_to(1'b0, k);
      check(8'(k), 8'd7, "odt on reference");
      i_ddrtr_ctrl_model.idle(4);
      i_ddrtr_ctrl_model.set_odt(1'b0);
      edges_to(1'b1, k);
      check(8'(k), 8'd7, "odt off reference");
   endtask

   task automatic t_cke();
      clr();
      i_ddrtr_ctrl_model.cke_hold(1'b1, 10);
      check({6'h00, cke_valid, clk_ok}, 8'h02, "cke high held");
      i_ddrtr_ctrl_model.cke_hold(1'b0, 10);
      check({6'h00, cke_valid, clk_ok}, 8'h03, "cke low held");
      check({7'h00, seen_err[1]}, 8'h00, "legal cke pulses");
      i_ddrtr_ctrl_model.cke_hold(1'b1, 2);
      i_ddrtr_ctrl_model.cke_hold(1'b0, 10);
      check({7'h00, seen_err[1]}, 8'h01, "short cke pulse");
   endtask

   initial begin
      sys_rst = 1'b1;
      seen_err = 4'h0;
      seen_rdv = 1'b0;
      repeat (5) @(posedge sys_clk);
      #1;
      t_reset();
      @(posedge sys_clk);
      sys_rst <= 1'b0;
      i_ddrtr_ctrl_model.idle(2);
      t_mode_dal();
      t_wtr();
      t_stale();
      t_odt();
      t_cke();
      conclude();
   end
endmodule
